// File: verilog/ata_status_control.sv
// Overview of operation
// - Status read clears interrupt; shadow read doesn't.
// - Busy locks host out of command register.
// - Ready bit zero until commands accepted.
// - Write fault flag follows fault events.
// - Seek complete set whenever card ready.
// - Data request set for transfer, cleared on transfer done or error.
// - Corrected data flag set, read continues.
// - Index flag always reads zero.
// - Error flag set on failure, cleared next command.
// - Device control writable even while busy.
// - Soft reset clears status except busy, which it sets; loads diagnostic code.
// - Interrupt disable gates request, resets to zero.
// - Write active bit low during writes.
// - Head select bits read inverted.
// - Drive select bits low when selected.
// - Class 1 sets busy within 400 ns.
// - Class 2: busy, data request within 700 us.
// - Class 3: busy, data request within 20 ms.
// - C5h, CDh, 3Ch decode as class 3.
// - 30h, 31h, 38h, E8h, CAh decode as class 2.
// - Every other opcode decodes as class 1.
`timescale 1ns/1ps

module ata_status_control
    import ata_status_pkg::*;
#(
    parameter int DREQ_CL2_CYCLES = DREQ_CL2_CYC,
    parameter int DREQ_CL3_CYCLES = DREQ_CL3_CYC,
    parameter int PREP_CYCLES     = 8,
    parameter int INIT_CYCLES     = 16
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Task-file access from the host interface.
    input  wire logic [3:0] tf_addr,
    input  wire logic       tf_rd,
    input  wire logic       tf_wr,
    input  wire logic [7:0] tf_wdata,
    output logic      [7:0] tf_rdata,
    // Drive/head register and drive number from neighbouring logic.
    input  wire logic [7:0] drive_head,
    input  wire logic       card_drive_num,
    // Events from the controller core.
    input  wire logic       write_fault_evt,
    input  wire logic       corrected_evt,
    input  wire logic       cmd_error_evt,
    input  wire logic       cmd_done_evt,
    input  wire logic       xfer_done_evt,
    // Status toward the controller core and host pins.
    output logic      [7:0] cmd_opcode,
    output logic            cmd_start,
    output logic            soft_reset_active,
    output logic      [7:0] diag_code,
    output logic            diag_load,
    output logic            pending_irq_flag,
    output logic            interrupt_request_n
);

    // ==================================================================
    // Reset synchroniser
    // ==================================================================
    logic rst_meta_reg;
    logic rst_sync_reg;

    // Only the second flop feeds the design, so a release that lands
    // close to an edge can only disturb the first one.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ==================================================================
    // Opcode decode
    // ==================================================================
    // Unlisted opcodes fall to class 1, so retired commands still raise
    // busy and complete as a no-operation.
    function automatic cmd_class_t decode_class(input logic [7:0] op);
        cmd_class_t c;
        case (op)
            OP_WR_MULT, OP_WR_MULT_NE, OP_WR_VERIFY:
                c = CLASS_3;
            OP_WR_SECT, OP_WR_SECT_NR, OP_WR_SECT_NE,
            OP_WR_BUFFER, OP_WR_DMA:
                c = CLASS_2;
            default:
                c = CLASS_1;
        endcase
        return c;
    endfunction

    // ==================================================================
    // Host strobes
    // ==================================================================
    ctl_state_t state_reg;
    logic [7:0] status_reg;
    logic       busy;
    logic       wr_cmd;
    logic       wr_ctl;
    logic       rd_status;

    assign busy      = status_reg[ST_BUSY];
    // Opcode writes while busy are dropped: the host is locked out.
    assign wr_cmd    = tf_wr && tf_addr == OFF_COMMAND && !busy
                       && state_reg == ST_IDLE;
    // Control writes bypass the busy lock, so the host can always reach
    // soft reset and the interrupt gate.
    assign wr_ctl    = tf_wr && tf_addr == OFF_DEV_CONTROL;
    assign rd_status = tf_rd && tf_addr == OFF_STATUS;

    // ==================================================================
    // Device control register
    // ==================================================================
    logic soft_reset_reg;
    logic int_dis_reg;

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            soft_reset_reg <= 1'b0;
            int_dis_reg    <= 1'b0;
        end else if (wr_ctl) begin
            soft_reset_reg <= tf_wdata[DC_SOFT_RESET];
            int_dis_reg    <= tf_wdata[DC_INT_DIS];
        end
    end

    // ==================================================================
    // Command acceptance sequencer
    // ==================================================================
    cmd_class_t class_reg;
    logic [31:0] timer_reg;
    logic        ready_reg;
    logic        writing_reg;

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg   <= ST_SRESET;
            class_reg   <= CLASS_1;
            timer_reg   <= 32'h0000_0000;
            ready_reg   <= 1'b0;
            writing_reg <= 1'b0;
        end else if (soft_reset_reg) begin
            state_reg   <= ST_SRESET;
            ready_reg   <= 1'b0;
            writing_reg <= 1'b0;
            timer_reg   <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_SRESET: begin
                    // Internal bring-up before commands are taken.
                    if (timer_reg == 32'(INIT_CYCLES)) begin
                        ready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                        timer_reg <= 32'h0000_0000;
                    end else begin
                        timer_reg <= timer_reg + 32'h0000_0001;
                    end
                end
                ST_IDLE: begin
                    if (wr_cmd) begin
                        class_reg <= decode_class(tf_wdata);
                        state_reg <= ST_ACCEPT;
                    end
                end
                ST_ACCEPT: begin
                    // Busy rises one cycle after the opcode, well
                    // inside the allowed window.
                    timer_reg <= 32'h0000_0000;
                    if (class_reg == CLASS_1) begin
                        state_reg <= ST_EXEC;
                    end else begin
                        writing_reg <= 1'b1;
                        state_reg   <= ST_PREP;
                    end
                end
                ST_PREP: begin
                    // Buffer setup time is far shorter than the limit.
                    timer_reg <= timer_reg + 32'h0000_0001;
                    if (timer_reg == 32'(PREP_CYCLES) ||
                        (class_reg == CLASS_2 &&
                         timer_reg == 32'(DREQ_CL2_CYCLES - 1)) ||
                        timer_reg == 32'(DREQ_CL3_CYCLES - 1)) begin
                        state_reg <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (xfer_done_evt || cmd_error_evt) begin
                        writing_reg <= 1'b0;
                        state_reg   <= ST_IDLE;
                    end
                end
                ST_EXEC: begin
                    if (cmd_done_evt || cmd_error_evt) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // Status register
    // ==================================================================
    logic [7:0] status_next;

    always_comb begin
        status_next = status_reg;
        status_next[ST_BUSY]  = state_reg == ST_ACCEPT ||
                                state_reg == ST_PREP ||
                                state_reg == ST_EXEC ||
                                state_reg == ST_SRESET;
        status_next[ST_READY] = ready_reg;
        status_next[ST_SEEK]  = ready_reg;
        status_next[ST_INDEX] = 1'b0;
        // Data request rises with busy dropping the same edge.
        status_next[ST_DREQ]  = state_reg == ST_XFER;
        if (state_reg == ST_ACCEPT) begin
            // A new command clears the sticky results.
            status_next[ST_FAULT]  = 1'b0;
            status_next[ST_WFAULT] = 1'b0;
            status_next[ST_FIXED]  = 1'b0;
        end
        if (write_fault_evt) begin
            status_next[ST_WFAULT] = 1'b1;
        end
        if (corrected_evt) begin
            // Only flagged; the transfer sequence is not disturbed.
            status_next[ST_FIXED] = 1'b1;
        end
        if (cmd_error_evt) begin
            status_next[ST_FAULT] = 1'b1;
        end
        if (soft_reset_reg) begin
            status_next = STATUS_RESET;
            status_next[ST_BUSY] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ==================================================================
    // Interrupt
    // ==================================================================
    logic irq_reg;
    logic cmd_end;
    logic xfer_entry;

    // Data request shows in the status register one cycle after the
    // transfer state is entered; raising the interrupt in that cycle
    // tells the host to move data exactly when it may.
    assign xfer_entry = state_reg == ST_XFER && !status_reg[ST_DREQ];
    assign cmd_end    = (state_reg == ST_EXEC && cmd_done_evt) ||
                        cmd_error_evt ||
                        xfer_entry;

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            irq_reg <= 1'b0;
        end else if (soft_reset_reg) begin
            irq_reg <= 1'b0;
        end else if (cmd_end) begin
            // A new event beats a simultaneous status read.
            irq_reg <= 1'b1;
        end else if (rd_status) begin
            irq_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pending_irq_flag    <= 1'b0;
            interrupt_request_n <= 1'b1;
        end else begin
            pending_irq_flag    <= irq_reg && !int_dis_reg;
            interrupt_request_n <= !(irq_reg && !int_dis_reg);
        end
    end

    // ==================================================================
    // Read data and core handshake
    // ==================================================================
    logic [7:0] drive_addr;
    logic       sel_drv;

    assign sel_drv = drive_head[4] == card_drive_num;
    always_comb begin
        drive_addr = 8'h00;
        // Bit 7 is don't care; it reads 1 like an undriven legacy line.
        drive_addr[7]          = 1'b1;
        drive_addr[DA_WRITE_N] = !writing_reg;
        drive_addr[DA_HEAD_HI:DA_HEAD_LO] = ~drive_head[3:0];
        drive_addr[DA_DRV1_N]  = !(sel_drv && card_drive_num);
        drive_addr[DA_DRV0_N]  = !(sel_drv && !card_drive_num);
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            tf_rdata <= 8'h00;
        end else if (tf_rd) begin
            case (tf_addr)
                OFF_STATUS, OFF_STATUS_SHADOW:
                    tf_rdata <= status_reg;
                OFF_DRIVE_ADDR:
                    tf_rdata <= drive_addr;
                default:
                    tf_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cmd_opcode        <= 8'h00;
            cmd_start         <= 1'b0;
            soft_reset_active <= 1'b0;
            diag_code         <= 8'h00;
            diag_load         <= 1'b0;
        end else begin
            cmd_start         <= wr_cmd;
            soft_reset_active <= soft_reset_reg;
            diag_load         <= wr_ctl && tf_wdata[DC_SOFT_RESET]
                                 && !soft_reset_reg;
            diag_code         <= DIAG_NO_ERROR;
            if (wr_cmd) begin
                cmd_opcode <= tf_wdata;
            end
        end
    end

endmodule

// File: verilog/ata_status_pkg.sv
package ata_status_pkg;

    // Task-file offsets seen by the host.
    localparam logic [3:0] OFF_COMMAND       = 4'h7;
    localparam logic [3:0] OFF_STATUS        = 4'h7;
    localparam logic [3:0] OFF_STATUS_SHADOW = 4'hE;
    localparam logic [3:0] OFF_DEV_CONTROL   = 4'hE;
    localparam logic [3:0] OFF_DRIVE_ADDR    = 4'hF;

    // Status bit positions.
    localparam int ST_BUSY    = 7;
    localparam int ST_READY   = 6;
    localparam int ST_WFAULT  = 5;
    localparam int ST_SEEK    = 4;
    localparam int ST_DREQ    = 3;
    localparam int ST_FIXED   = 2;
    localparam int ST_INDEX   = 1;
    localparam int ST_FAULT   = 0;

    // Device control bit positions.
    localparam int DC_SOFT_RESET = 2;
    localparam int DC_INT_DIS    = 1;

    // Drive address bit positions.
    localparam int DA_WRITE_N   = 6;
    localparam int DA_HEAD_HI   = 5;
    localparam int DA_HEAD_LO   = 2;
    localparam int DA_DRV1_N    = 1;
    localparam int DA_DRV0_N    = 0;

    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] DIAG_NO_ERROR  = 8'h01;

    // Class 2 and class 3 opcodes.
    localparam logic [7:0] OP_WR_SECT     = 8'h30;
    localparam logic [7:0] OP_WR_SECT_NR  = 8'h31;
    localparam logic [7:0] OP_WR_SECT_NE  = 8'h38;
    localparam logic [7:0] OP_WR_BUFFER   = 8'hE8;
    localparam logic [7:0] OP_WR_DMA      = 8'hCA;
    localparam logic [7:0] OP_WR_MULT     = 8'hC5;
    localparam logic [7:0] OP_WR_MULT_NE  = 8'hCD;
    localparam logic [7:0] OP_WR_VERIFY   = 8'h3C;

    // Timing, in the units printed, then in 20 ns clock cycles.
    localparam int CLK_PERIOD_NS   = 20;
    localparam int BUSY_SET_NS     = 400;
    localparam int DREQ_CL2_US     = 700;
    localparam int DREQ_CL3_MS     = 20;
    localparam int BUSY_SET_CYC    = BUSY_SET_NS / CLK_PERIOD_NS;
    localparam int DREQ_CL2_CYC    = DREQ_CL2_US * 1000 / CLK_PERIOD_NS;
    localparam int DREQ_CL3_CYC    = DREQ_CL3_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CLASS_1 = 2'b01,
        CLASS_2 = 2'b10,
        CLASS_3 = 2'b11
    } cmd_class_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ACCEPT  = 3'b001,
        ST_EXEC    = 3'b010,
        ST_PREP    = 3'b011,
        ST_XFER    = 3'b100,
        ST_SRESET  = 3'b101
    } ctl_state_t;

endpackage

// File: test/ata_status_control_sva.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checks of the task-file status block.
module ata_status_control_sva
    import ata_status_pkg::*;
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rst_n,
    // Task-file side.
    input wire logic [3:0] tf_addr,
    input wire logic       tf_rd,
    input wire logic       tf_wr,
    input wire logic [7:0] tf_wdata,
    input wire logic [7:0] tf_rdata,
    input wire logic [7:0] drive_head,
    input wire logic       card_drive_num,
    // Core side.
    input wire logic [7:0] cmd_opcode,
    input wire logic       cmd_start,
    input wire logic       soft_reset_active,
    input wire logic [7:0] diag_code,
    input wire logic       diag_load,
    input wire logic       pending_irq_flag,
    input wire logic       interrupt_request_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // The flag is registered, so the clear may land one edge late.
    AST_STATUS_READ_CLEARS_IRQ: assert property (
        tf_rd && tf_addr == OFF_STATUS |-> ##[1:2] !pending_irq_flag)
        else $error("status read left interrupt pending");
    AST_SHADOW_READ_KEEPS_IRQ: assert property (
        tf_rd && !tf_wr && tf_addr == OFF_STATUS_SHADOW && pending_irq_flag
        |=> pending_irq_flag)
        else $error("shadow read cleared interrupt");
    AST_INDEX_ZERO: assert property (
        tf_rd && tf_addr == OFF_STATUS |=> !tf_rdata[ST_INDEX])
        else $error("index bit read as one");
    AST_IRQ_DISABLE: assert property (
        tf_wr && tf_addr == OFF_DEV_CONTROL && tf_wdata[DC_INT_DIS]
        |-> ##[1:3] (!pending_irq_flag && interrupt_request_n))
        else $error("interrupt not suppressed");
    AST_SRESET_SET: assert property (
        tf_wr && tf_addr == OFF_DEV_CONTROL && tf_wdata[DC_SOFT_RESET]
        |-> ##[1:2] soft_reset_active)
        else $error("soft reset not entered");
    AST_SRESET_CLEAR: assert property (
        tf_wr && tf_addr == OFF_DEV_CONTROL && !tf_wdata[DC_SOFT_RESET]
        |-> ##[1:2] !soft_reset_active)
        else $error("soft reset not left");
    AST_SRESET_DIAG: assert property (
        // The load pulse leads the mirrored level by one cycle.
        $rose(soft_reset_active)
        |-> $past(diag_load) && diag_code == DIAG_NO_ERROR)
        else $error("diagnostic code not loaded");
    AST_CMD_START_CAUSE: assert property (
        cmd_start |-> $past(tf_wr) && $past(tf_addr) == OFF_COMMAND
        && cmd_opcode == $past(tf_wdata))
        else $error("command start without opcode write");
    AST_HEAD_INVERTED: assert property (
        tf_rd && tf_addr == OFF_DRIVE_ADDR
        |=> tf_rdata[5:2] == ~$past(drive_head[3:0]))
        else $error("head select not inverted");
    AST_DRIVE0_SEL: assert property (
        tf_rd && tf_addr == OFF_DRIVE_ADDR && !drive_head[4]
        && !card_drive_num |=> !tf_rdata[DA_DRV0_N])
        else $error("drive 0 select bit high");

    COV_CMD: cover property (cmd_start);
    COV_DIAG: cover property (diag_load);
    COV_IRQ: cover property ($fell(interrupt_request_n));
endmodule

// File: test/host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host adapter: one-cycle strobes, driven on the falling edge.
module host_model (
    // Clock.
    input  wire logic       clk,
    // Strobes toward the card.
    output logic      [3:0] tf_addr,
    output logic            tf_rd,
    output logic            tf_wr,
    output logic      [7:0] tf_wdata,
    // Read data from the card.
    input  wire logic [7:0] tf_rdata
);
    initial begin
        tf_addr = 4'h0;
        tf_rd = 1'b0;
        tf_wr = 1'b0;
        tf_wdata = 8'h00;
    end
    // Callers keep devctl high bits zero; opcode 30h is sent while busy after each class 1 opcode.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        tf_addr = a;
        tf_wdata = d;
        tf_wr = 1'b1;
        @(negedge clk);
        tf_wr = 1'b0;
        // A released bus must not keep showing the last byte.
        tf_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        tf_addr = a;
        tf_rd = 1'b1;
        @(negedge clk);
        tf_rd = 1'b0;
        d = tf_rdata;
    endtask
endmodule

// File: test/ata_status_control_tb.sv
`timescale 1ns/1ps
module ata_status_control_tb;
    import ata_status_pkg::*;
    localparam int PREP = 8;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] tf_addr;
    logic       tf_rd;
    logic       tf_wr;
    logic [7:0] tf_wdata;
    logic [7:0] tf_rdata;
    logic [7:0] drive_head = 8'hA0;
    logic       card_drive_num = 1'b0;
    logic [4:0] evt = 5'h00;
    logic [7:0] cmd_opcode;
    logic [7:0] diag_code;
    logic       cmd_start;
    logic       soft_reset_active;
    logic       diag_load;
    logic       pending_irq_flag;
    logic       interrupt_request_n;
    int         num_errors = 0;
    int         num_checks = 0;
    logic [31:0] seed = 32'h0000_0016;
    logic [31:0] r;
    logic [7:0] s;
    logic [7:0] op;
    logic [7:0] exp;
    logic [7:0] ops [12] = '{8'h00, 8'h20, 8'hEC, 8'hC5, 8'hCD, 8'h3C,
                             8'h30, 8'h31, 8'h38, 8'hE8, 8'hCA, 8'h90};

    always #10 clk = ~clk;

    host_model h (.clk(clk), .tf_addr(tf_addr), .tf_rd(tf_rd),
                  .tf_wr(tf_wr), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata));

    ata_status_control #(.DREQ_CL2_CYCLES(100), .DREQ_CL3_CYCLES(200),
                         .PREP_CYCLES(PREP), .INIT_CYCLES(16)) DUT (
        .clk(clk), .rst_n(rst_n), .tf_addr(tf_addr), .tf_rd(tf_rd),
        .tf_wr(tf_wr), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata),
        .drive_head(drive_head), .card_drive_num(card_drive_num),
        .write_fault_evt(evt[0]), .corrected_evt(evt[1]),
        .cmd_error_evt(evt[2]), .cmd_done_evt(evt[3]),
        .xfer_done_evt(evt[4]), .cmd_opcode(cmd_opcode),
        .cmd_start(cmd_start), .soft_reset_active(soft_reset_active),
        .diag_code(diag_code), .diag_load(diag_load),
        .pending_irq_flag(pending_irq_flag),
        .interrupt_request_n(interrupt_request_n));

    // ============================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [1:0] cls(input logic [7:0] o);
        case (o)
            8'hC5, 8'hCD, 8'h3C: cls = 2'd3;
            8'h30, 8'h31, 8'h38, 8'hE8, 8'hCA: cls = 2'd2;
            default: cls = 2'd1;
        endcase
    endfunction
    function automatic logic [7:0] da(input logic [7:0] dh,
                                      input logic c, input logic w);
        return {1'b1, w, ~dh[3:0], !(dh[4] && c), !(!dh[4] && !c)};
    endfunction
    task automatic chk(input string n, input logic [7:0] seen,
                       input logic [7:0] e);
        num_checks++;
        if (seen !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, seen);
        end
    endtask
    task automatic pulse(input logic [4:0] m);
        @(negedge clk);
        evt = m;
        @(negedge clk);
        evt = 5'h00;
    endtask
    task automatic wait_idle(output logic [7:0] st);
        int n;
        n = 0;
        h.rd(OFF_STATUS, st);
        while (st[7] !== 1'b0 && n < 60) begin
            h.rd(OFF_STATUS, st);
            n++;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        h.rd(OFF_STATUS, s);
        chk("init busy ready", {6'h00, s[7:6]}, 8'h02);
        wait_idle(s);
        chk("idle status", s, 8'h50);
        for (int i = 0; i < 14; i++) begin
            r = xs();
            op = (i < 12) ? ops[i] : r[31:24];
            drive_head = {3'b101, r[12:8]};
            card_drive_num = r[13];
            h.wr(OFF_DEV_CONTROL, {6'h00, r[14], 1'b0});
            h.rd(OFF_DRIVE_ADDR, s);
            chk("drive addr", s, da(drive_head, r[13], 1'b1));
            h.wr(OFF_COMMAND, op);
            repeat (2) @(negedge clk);
            h.rd(OFF_STATUS, s);
            chk("busy set", {7'h00, s[7]}, 8'h01);
            if (cls(op) == 2'd1) begin
                // Opcode while busy must be dropped.
                h.wr(OFF_COMMAND, 8'h30);
                pulse({2'b00, r[17:15]});
                repeat (PREP + 4) @(negedge clk);
                // Shadow read, so an error interrupt stays pending.
                h.rd(OFF_STATUS_SHADOW, s);
                exp = {6'h00, !r[17], 1'b0};
                chk("class 1 busy", {6'h00, s[7], s[3]}, exp);
                chk("opcode kept", cmd_opcode, op);
                pulse(5'h08);
                exp = {2'b01, r[15], 2'b10, r[16], 1'b0, r[17]};
            end else begin
                repeat (PREP + 4) @(negedge clk);
                exp = 8'h58;
            end
            repeat (3) @(negedge clk);
            chk("irq flag", {7'h00, pending_irq_flag}, {7'h00, !r[14]});
            chk("irq line", {7'h00, interrupt_request_n}, {7'h00, r[14]});
            h.rd(OFF_STATUS_SHADOW, s);
            chk("shadow", s, exp);
            h.rd(OFF_STATUS, s);
            chk("status", s, exp);
            @(negedge clk);
            chk("irq cleared", {7'h00, pending_irq_flag}, 8'h00);
            if (cls(op) != 2'd1) begin
                h.rd(OFF_DRIVE_ADDR, s);
                chk("write active", {7'h00, s[6]}, 8'h00);
                pulse(5'h10);
                pulse(5'h08);
                wait_idle(s);
                chk("after write", s, 8'h50);
                h.rd(OFF_DRIVE_ADDR, s);
                chk("write ended", s, da(drive_head, r[13], 1'b1));
            end
        end
        h.wr(OFF_DEV_CONTROL, 8'h04);
        repeat (3) @(negedge clk);
        chk("soft reset", {7'h00, soft_reset_active}, 8'h01);
        h.rd(OFF_STATUS, s);
        chk("status in reset", s, 8'h80);
        h.wr(OFF_DEV_CONTROL, 8'h00);
        wait_idle(s);
        chk("status after reset", s, 8'h50);
        end_sim;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim;
    end
endmodule

bind ata_status_control ata_status_control_sva u_sva (
    .clk(clk), .rst_n(rst_n), .tf_addr(tf_addr), .tf_rd(tf_rd),
    .tf_wr(tf_wr), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata),
    .drive_head(drive_head), .card_drive_num(card_drive_num),
    .cmd_opcode(cmd_opcode), .cmd_start(cmd_start),
    .soft_reset_active(soft_reset_active), .diag_code(diag_code),
    .diag_load(diag_load), .pending_irq_flag(pending_irq_flag),
    .interrupt_request_n(interrupt_request_n));
